// *** common/ptg_defs.svh ***
`ifndef PTG_DEFS_SVH
`define PTG_DEFS_SVH

`define PTG_ADDR_W 12
`define PTG_OFF_CTRL 12'h000
`define PTG_OFF_STATUS 12'h004
`define PTG_OFF_IRQ_EN 12'h008
`define PTG_OFF_IRQ_CLR 12'h00C
`define PTG_OFF_DEBUG 12'h010
`define PTG_OFF_LIST 12'h014
`define PTG_OFF_TNUM 12'h018
`define PTG_OFF_TV 12'h01C

`define PTG_BIT_LOAD_OK 0
`define PTG_BIT_DONE 0
`define PTG_BIT_ERR 1
`define PTG_BIT_FORCE_TRIG 0
`define PTG_BIT_FORCE_RELOAD 2

`define PTG_RST_CTRL 1'h0
`define PTG_RST_FLAGS 2'h0
`define PTG_RST_TV 16'h0000
`define PTG_RST_CNT 6'h00

`define PTG_TRIG_END 16'h0000
`define PTG_MAX_TRIG 6'h20

`endif

// *** common/ptg_pkg.sv ***
package ptg_pkg;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_FETCH = 2'b01,
      ST_WAIT = 2'b10,
      ST_HALT = 2'b11
   } ptg_state_e;

   typedef struct packed {
      logic valid;
      logic list;
      logic [5:0] index;
   } ptg_fetch_req_s;

   typedef struct packed {
      logic valid;
      logic ecc_dbl;
      logic [15:0] data;
   } ptg_fetch_rsp_s;

endpackage

// *** verilog/ptg_timebase.sv ***
`timescale 1ns/10ps
`default_nettype none
module ptg_timebase (
   input wire logic core_clk_i,
   input wire logic reset_i,
   input wire logic clear_i,
   output logic [15:0] count_o
);

   logic [15:0] count_reg;
   logic [15:0] count_next;

   // The counter wraps at the top; each reload restarts it from zero.
   always_comb begin
      if (clear_i) begin
         count_next = 16'h0000;
      end else begin
         count_next = count_reg + 16'h0001;
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (reset_i) begin
         count_reg <= 16'h0000;
      end else begin
         count_reg <= count_next;
      end
   end

   assign count_o = count_reg;

endmodule
`default_nettype wire

// *** verilog/ptg_sequencer.sv ***
// The address map and the APB interface to the registers were left to the implementer.
`timescale 1ns/10ps
`default_nettype none
`include "ptg_defs.svh"

// Behaviour
// - Done on zero entry or 32 triggers.
// - Done raised only after fetch completes.
// - Done interrupt when its enable set.
// - ECC error: flag, discard, no done.
// - Error interrupt when its enable set.
// - Active list readable.
// - Trigger count readable, zero at maximum.
// - Fetched next trigger value readable.
// - Readbacks hold after list end.
// - Reload clears count, swaps if load-ok.
// - Force bits create reload or trigger (the trigger only while in ST_WAIT).
// - Force bits ignored in stop/freeze.
// - One 16-bit time base counter.
module ptg_sequencer (
   input wire logic core_clk_i,
   input wire logic reset_i,
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [11:0] paddr_i,
   input wire logic [31:0] pwdata_i,
   output logic [31:0] prdata_o,
   output logic pready_o,
   output logic pslverr_o,
   input wire logic pwm_reload_i,
   input wire logic stop_mode_i,
   input wire logic freeze_mode_i,
   output ptg_pkg::ptg_fetch_req_s fetch_req_o,
   input wire ptg_pkg::ptg_fetch_rsp_s fetch_rsp_i,
   output logic trigger_o,
   output logic irq_o
);

   function automatic logic hit(input logic [11:0] addr, input logic [11:0] off);
      hit = (addr[11:2] == off[11:2]);
   endfunction

   function automatic logic mapped(input logic [11:0] addr);
      mapped = hit(addr, `PTG_OFF_CTRL) | hit(addr, `PTG_OFF_STATUS) |
         hit(addr, `PTG_OFF_IRQ_EN) | hit(addr, `PTG_OFF_IRQ_CLR) |
         hit(addr, `PTG_OFF_DEBUG) | hit(addr, `PTG_OFF_LIST) |
         hit(addr, `PTG_OFF_TNUM) | hit(addr, `PTG_OFF_TV);
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   logic apb_wr;
   logic apb_setup;
   logic force_ok;
   logic force_reload;
   logic force_trig;
   logic reload_evt;
   logic [15:0] tb_count;
   logic ldok_reg;
   logic ldok_next;
   logic [1:0] irq_en_reg;
   logic [1:0] irq_en_next;
   logic [31:0] prdata_reg;
   logic [31:0] prdata_next;
   logic [1:0] flag_reg;
   logic [1:0] flag_next;
   logic done_set;
   logic err_set;
   ptg_pkg::ptg_state_e st_reg;
   ptg_pkg::ptg_state_e st_next;
   logic [5:0] cnt_reg;
   logic [5:0] cnt_next;
   logic [15:0] tv_reg;
   logic [15:0] tv_next;
   logic list_reg;
   logic list_next;
   logic trig_reg;
   logic trig_next;
   logic fetch_ok;

   assign apb_setup = psel_i & ~penable_i;
   assign apb_wr = psel_i & penable_i & pwrite_i;
   assign pready_o = penable_i;
   assign pslverr_o = psel_i & penable_i & ~mapped(paddr_i);
   assign prdata_o = prdata_reg;

   assign force_ok = ~stop_mode_i & ~freeze_mode_i;
   assign force_reload = apb_wr & hit(paddr_i, `PTG_OFF_DEBUG) &
      pwdata_i[`PTG_BIT_FORCE_RELOAD] & force_ok;
   assign force_trig = apb_wr & hit(paddr_i, `PTG_OFF_DEBUG) &
      pwdata_i[`PTG_BIT_FORCE_TRIG] & force_ok;
   assign reload_evt = pwm_reload_i | force_reload;

   ptg_timebase u_timebase (
      .core_clk_i(core_clk_i),
      .reset_i(reset_i),
      .clear_i(reload_evt),
      .count_o(tb_count)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Register file: control bits written in the access phase, read data captured in the setup phase.
   always_comb begin
      ldok_next = ldok_reg;
      irq_en_next = irq_en_reg;
      prdata_next = prdata_reg;
      if (reload_evt) begin
         ldok_next = 1'b0;
      end
      if (apb_wr & hit(paddr_i, `PTG_OFF_CTRL)) begin
         ldok_next = pwdata_i[`PTG_BIT_LOAD_OK];
      end
      if (apb_wr & hit(paddr_i, `PTG_OFF_IRQ_EN)) begin
         irq_en_next = pwdata_i[1:0];
      end
      if (apb_setup) begin
         prdata_next = 32'h00000000;
         if (hit(paddr_i, `PTG_OFF_CTRL)) begin
            prdata_next[`PTG_BIT_LOAD_OK] = ldok_reg;
         end
         if (hit(paddr_i, `PTG_OFF_STATUS)) begin
            prdata_next[1:0] = flag_reg;
         end
         if (hit(paddr_i, `PTG_OFF_IRQ_EN)) begin
            prdata_next[1:0] = irq_en_reg;
         end
         if (hit(paddr_i, `PTG_OFF_LIST)) begin
            prdata_next[0] = list_reg;
         end
         if (hit(paddr_i, `PTG_OFF_TNUM)) begin
            prdata_next[4:0] = cnt_reg[4:0];
         end
         if (hit(paddr_i, `PTG_OFF_TV)) begin
            prdata_next[15:0] = tv_reg;
         end
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (reset_i) begin
         ldok_reg <= `PTG_RST_CTRL;
         irq_en_reg <= `PTG_RST_FLAGS;
         prdata_reg <= 32'h00000000;
      end else begin
         ldok_reg <= ldok_next;
         irq_en_reg <= irq_en_next;
         prdata_reg <= prdata_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Sticky flags; a set in the clearing cycle survives the clear.
   always_comb begin
      flag_next = flag_reg;
      if (apb_wr & hit(paddr_i, `PTG_OFF_IRQ_CLR)) begin
         flag_next = flag_reg & ~pwdata_i[1:0];
      end
      if (done_set) begin
         flag_next[`PTG_BIT_DONE] = 1'b1;
      end
      if (err_set) begin
         flag_next[`PTG_BIT_ERR] = 1'b1;
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (reset_i) begin
         flag_reg <= `PTG_RST_FLAGS;
      end else begin
         flag_reg <= flag_next;
      end
   end

   assign irq_o = |(flag_reg & irq_en_reg);

   ////////////////////////////////////////////////////////////////////////////
   // List sequencer.
   assign fetch_ok = (st_reg == ptg_pkg::ST_FETCH) & fetch_rsp_i.valid;
   assign fetch_req_o = {(st_reg == ptg_pkg::ST_FETCH), list_reg, cnt_reg};
   assign trigger_o = trig_reg;

   always_comb begin
      st_next = st_reg;
      cnt_next = cnt_reg;
      tv_next = tv_reg;
      list_next = list_reg;
      trig_next = 1'b0;
      done_set = 1'b0;
      err_set = 1'b0;
      if (reload_evt) begin
         cnt_next = `PTG_RST_CNT;
         list_next = list_reg ^ ldok_reg;
         st_next = ptg_pkg::ST_FETCH;
      end else begin
         case (st_reg)
            ptg_pkg::ST_FETCH: begin
               if (fetch_rsp_i.valid) begin
                  st_next = ptg_pkg::ST_HALT;
                  if (fetch_rsp_i.ecc_dbl) begin
                     err_set = 1'b1;
                  end else if ((fetch_rsp_i.data == `PTG_TRIG_END) ||
                     (cnt_reg == `PTG_MAX_TRIG)) begin
                     done_set = 1'b1;
                  end else begin
                     tv_next = fetch_rsp_i.data;
                     st_next = ptg_pkg::ST_WAIT;
                  end
               end
            end
            ptg_pkg::ST_WAIT: begin
               if ((tb_count == tv_reg) | force_trig) begin
                  trig_next = 1'b1;
                  cnt_next = cnt_reg + 6'h01;
                  st_next = ptg_pkg::ST_FETCH;
               end
            end
            ptg_pkg::ST_HALT: begin
               st_next = ptg_pkg::ST_HALT;
            end
            ptg_pkg::ST_IDLE: begin
               st_next = ptg_pkg::ST_IDLE;
            end
            default: begin
               st_next = ptg_pkg::ST_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (reset_i) begin
         st_reg <= ptg_pkg::ST_IDLE;
         cnt_reg <= `PTG_RST_CNT;
         tv_reg <= `PTG_RST_TV;
         list_reg <= 1'b0;
         trig_reg <= 1'b0;
      end else begin
         st_reg <= st_next;
         cnt_reg <= cnt_next;
         tv_reg <= tv_next;
         list_reg <= list_next;
         trig_reg <= trig_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge core_clk_i);
   endclocking
   default disable iff (reset_i);

   sequence seq_good_fetch;
      fetch_ok && !fetch_rsp_i.ecc_dbl && !reload_evt;
   endsequence

   sequence seq_halted;
      st_reg == ptg_pkg::ST_HALT && !reload_evt;
   endsequence

   AST_DONE_ZERO: assert property (seq_good_fetch and
      (fetch_rsp_i.data == `PTG_TRIG_END) |=> flag_reg[`PTG_BIT_DONE])
      else $error("done not set on end entry");
   AST_DONE_MAX: assert property (seq_good_fetch and (cnt_reg == `PTG_MAX_TRIG)
      |=> flag_reg[`PTG_BIT_DONE] && st_reg == ptg_pkg::ST_HALT)
      else $error("done not set at maximum count");
   AST_DONE_AFTER_FETCH: assert property ($rose(flag_reg[`PTG_BIT_DONE]) |->
      $past(fetch_ok))
      else $error("done raised without a completed fetch");
   AST_IRQ_DONE: assert property (done_set && irq_en_reg[0] && !apb_wr |=> irq_o)
      else $error("done interrupt missing");
   AST_ECC: assert property (fetch_ok && fetch_rsp_i.ecc_dbl && !reload_evt |=>
      flag_reg[`PTG_BIT_ERR] && $stable(tv_reg) && st_reg == ptg_pkg::ST_HALT)
      else $error("ecc entry not discarded");
   AST_IRQ_ERR: assert property (err_set && irq_en_reg[1] && !apb_wr |=> irq_o)
      else $error("error interrupt missing");
   AST_LIST_READ: assert property (apb_setup && hit(paddr_i, `PTG_OFF_LIST) |=>
      prdata_o == {31'h00000000, $past(list_reg)})
      else $error("list readback wrong");
   AST_CNT_MAX_ZERO: assert property (apb_setup && hit(paddr_i, `PTG_OFF_TNUM) &&
      cnt_reg == `PTG_MAX_TRIG |=> prdata_o == 32'h00000000)
      else $error("count not zero at maximum");
   AST_TV_READ: assert property (seq_good_fetch and (st_next == ptg_pkg::ST_WAIT)
      |=> tv_reg == $past(fetch_rsp_i.data))
      else $error("next value not captured");
   AST_HOLD: assert property (seq_halted |=> $stable(cnt_reg) && $stable(tv_reg)
      && $stable(list_reg))
      else $error("readbacks changed after list end");
   AST_RELOAD: assert property (reload_evt |=> cnt_reg == `PTG_RST_CNT &&
      list_reg == ($past(list_reg) ^ $past(ldok_reg)))
      else $error("reload did not clear or swap");
   AST_FORCE_RELOAD: assert property (apb_wr && hit(paddr_i, `PTG_OFF_DEBUG) &&
      pwdata_i[`PTG_BIT_FORCE_RELOAD] && force_ok |=> tb_count == 16'h0000 &&
      st_reg == ptg_pkg::ST_FETCH)
      else $error("forced reload had no effect");
   AST_FORCE_BLOCKED: assert property ((stop_mode_i || freeze_mode_i) &&
      !pwm_reload_i && st_reg == ptg_pkg::ST_HALT |=> st_reg == ptg_pkg::ST_HALT)
      else $error("forced event acted in stop or freeze");
   AST_TIMEBASE: assert property (!reload_evt |=>
      tb_count == $past(tb_count) + 16'h0001)
      else $error("time base did not advance");
   AST_MATCH: assert property (st_reg == ptg_pkg::ST_WAIT && tb_count == tv_reg &&
      !reload_evt |=> trigger_o && st_reg == ptg_pkg::ST_FETCH)
      else $error("no trigger on match");

endmodule
`default_nettype wire

// *** sim/ptg_mem_model.sv ***
`timescale 1ns/10ps
`default_nettype none
// Memory fetch path: answers each entry request after lat_i + 1 idle cycles.
module ptg_mem_model (
   input wire logic core_clk_i,
   input wire logic reset_i,
   input wire ptg_pkg::ptg_fetch_req_s req_i,
   input wire logic [1:0] lat_i,
   output ptg_pkg::ptg_fetch_rsp_s rsp_o
);
   logic [15:0] lst [2][33];
   logic [6:0] ecc_at = '0;
   logic [1:0] cnt;
   logic vld;
   logic [15:0] ent;
   always_ff @(posedge core_clk_i) begin
      if (reset_i || !req_i.valid || vld) begin
         cnt <= '0;
         vld <= 1'b0;
      end else if (cnt == lat_i) begin
         vld <= 1'b1;
      end else begin
         cnt <= cnt + 2'h1;
      end
   end
   // Outside a response the data lines carry the inverse of the entry.
   always_comb begin
      ent = lst[req_i.list][req_i.index];
      rsp_o.valid = vld;
      rsp_o.ecc_dbl = vld && (ecc_at == {1'b1, req_i.index});
      rsp_o.data = vld ? ent : ~ent;
   end
endmodule
`default_nettype wire

// *** sim/ptg_sequencer_tb_top.sv ***
`timescale 1ns/10ps
`default_nettype none
`include "ptg_defs.svh"
module ptg_sequencer_tb_top;
   logic core_clk_i = 1'b0, reset_i = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [11:0] paddr = '0;
   logic [31:0] pwdata = '0, prdata, rd;
   logic pready, pslverr, er, trig, irq, pwm = 1'b0, stop = 1'b0, frz = 1'b0;
   logic [1:0] lat = '0;
   ptg_pkg::ptg_fetch_req_s req;
   ptg_pkg::ptg_fetch_rsp_s rsp;
   int n_errors = 0, tests_run = 0, cyc = 0;
   int tq[$];
   logic [15:0] v[33];

   ptg_sequencer ptg_sequencer_i (.core_clk_i(core_clk_i), .reset_i(reset_i), .psel_i(psel),
      .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
      .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr), .pwm_reload_i(pwm),
      .stop_mode_i(stop), .freeze_mode_i(frz), .fetch_req_o(req), .fetch_rsp_i(rsp),
      .trigger_o(trig), .irq_o(irq));
   ptg_mem_model ptg_mem_model_i (.core_clk_i(core_clk_i), .reset_i(reset_i), .req_i(req),
      .lat_i(lat), .rsp_o(rsp));

   initial begin
      forever #10 core_clk_i = ~core_clk_i;
   end
   always @(posedge core_clk_i) begin
      cyc <= cyc + 1;
      if (trig === 1'b1) tq.push_back(cyc);
   end

   ////////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         n_errors++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      n = 0;
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge core_clk_i);
      penable <= 1'b1;
      do begin
         @(posedge core_clk_i);
         n++;
      end while (pready !== 1'b1 && n < 50);
      if (n >= 50) n_errors++;
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge core_clk_i);
   endtask
   // Fills one list with rising trigger times; n entries, then zeros.
   task automatic fill(input int l, input int n, input int gap);
      logic [15:0] t;
      t = 16'h0010;
      for (int k = 0; k < 33; k++) begin
         t = t + 16'(gap + $urandom_range(0, 7));
         v[k] = (k < n) ? t : 16'h0000;
         ptg_mem_model_i.lst[l][k] = v[k];
      end
      lat <= 2'($urandom_range(0, 3));
   endtask
   // Starts a list (PWM pulse when dbg is zero) and polls status until a flag shows.
   task automatic run(input logic [31:0] dbg);
      int n;
      n = 0;
      if (dbg == 32'h0) begin
         pwm <= 1'b1;
         @(posedge core_clk_i);
         pwm <= 1'b0;
      end else apb(1'b1, `PTG_OFF_DEBUG, dbg);
      do begin
         apb(1'b0, `PTG_OFF_STATUS, 32'h0);
         n++;
      end while (rd === 32'h0 && n < 500);
   endtask
   function automatic logic [31:0] tnum_exp(input int n);
      return (n >= 32) ? 32'h0 : 32'(n);
   endfunction
   task automatic wrap_up();
      if (n_errors == 0 && tests_run > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (20000) @(posedge core_clk_i);
      n_errors++;
      wrap_up();
   end
   initial begin
      void'($urandom(52918));
      repeat (8) @(posedge core_clk_i);
      reset_i <= 1'b0;
      @(posedge core_clk_i);
      for (int k = 0; k < 8; k++) begin
         apb(1'b0, 12'(k * 4), 32'h0);
         if (k != 3) chk(rd, 32'h0);
      end
      chk(irq, 1'b0);
      apb(1'b1, 12'h020, 32'hFFFF_FFFF);
      chk(er, 1'b1);
      apb(1'b0, 12'h020, 32'h0);
      chk(rd, 32'h0);
      // Short list ended by a zero entry, interrupt masked then enabled.
      fill(0, 3, 12);
      run(32'h0);
      chk(rd, 32'h1);
      chk(tq.size(), 3);
      chk(tq[2] - tq[1], v[2] - v[1]);
      chk(irq, 1'b0);
      apb(1'b0, `PTG_OFF_TNUM, 32'h0);
      chk(rd, tnum_exp(3));
      repeat (20) @(posedge core_clk_i);
      apb(1'b0, `PTG_OFF_TV, 32'h0);
      chk(rd, 32'(v[2]));
      apb(1'b0, `PTG_OFF_LIST, 32'h0);
      chk(rd, 32'h0);
      apb(1'b1, `PTG_OFF_IRQ_EN, 32'h1);
      chk(irq, 1'b1);
      apb(1'b1, `PTG_OFF_IRQ_CLR, 32'h1);
      chk(irq, 1'b0);
      // Full list of 32 triggers on the other list.
      apb(1'b1, `PTG_OFF_CTRL, 32'h1);
      fill(1, 33, 12);
      tq.delete();
      run(32'h0);
      chk(rd, 32'h1);
      chk(tq.size(), 32);
      chk(irq, 1'b1);
      apb(1'b0, `PTG_OFF_TNUM, 32'h0);
      chk(rd, tnum_exp(32));
      apb(1'b0, `PTG_OFF_LIST, 32'h0);
      chk(rd, 32'h1);
      apb(1'b0, `PTG_OFF_CTRL, 32'h0);
      chk(rd, 32'h0);
      // Double-bit error on the second entry.
      apb(1'b1, `PTG_OFF_IRQ_CLR, 32'h3);
      apb(1'b1, `PTG_OFF_IRQ_EN, 32'h2);
      fill(1, 5, 12);
      ptg_mem_model_i.ecc_at = 7'h41;
      tq.delete();
      run(32'h0);
      chk(rd, 32'h2);
      chk(tq.size(), 1);
      chk(irq, 1'b1);
      apb(1'b0, `PTG_OFF_TV, 32'h0);
      chk(rd, 32'(v[0]));
      apb(1'b0, `PTG_OFF_LIST, 32'h0);
      chk(rd, 32'h1);
      ptg_mem_model_i.ecc_at = 7'h00;
      apb(1'b1, `PTG_OFF_IRQ_CLR, 32'h3);
      // Software reload and trigger, blocked in freeze and stop.
      fill(0, 1, 30000);
      apb(1'b1, `PTG_OFF_CTRL, 32'h1);
      frz <= 1'b1;
      apb(1'b1, `PTG_OFF_DEBUG, 32'h4);
      frz <= 1'b0;
      apb(1'b0, `PTG_OFF_LIST, 32'h0);
      chk(rd, 32'h1);
      apb(1'b1, `PTG_OFF_DEBUG, 32'h4);
      apb(1'b0, `PTG_OFF_LIST, 32'h0);
      chk(rd, 32'h0);
      repeat (10) @(posedge core_clk_i);
      tq.delete();
      stop <= 1'b1;
      apb(1'b1, `PTG_OFF_DEBUG, 32'h1);
      stop <= 1'b0;
      // A stray trigger pulse is only logged one edge after the write ends.
      @(posedge core_clk_i);
      chk(tq.size(), 0);
      run(32'h1);
      chk(rd, 32'h1);
      chk(tq.size(), 1);
      apb(1'b0, `PTG_OFF_TNUM, 32'h0);
      chk(rd, tnum_exp(1));
      wrap_up();
   end
endmodule
`default_nettype wire
